//--- pic_clock_ctrl.v
// Added by the designer: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "pic_consts.vh"
// Summary of operation
// - clearing interrupt enable withdraws pending request
// - rate bits 5:3 select count source
// - mode bits 2:1 select modes 0-3
// - setting run bit starts counting
// - modes 1-3 keep run bit set
// - mode 0 self-clears run on overflow
// - run clear zeroes and holds counter
// - every overflow sets overflow flag
// - enabled flag raises interrupt, even late
// - internal rates derive from 10 MHz
module pic_clock_ctrl (
	input  wire        CLK_IN,
	input  wire        RST_IN,
	input  wire        CE_IN,
	input  wire        EVENT_INPUT_ONE_IN,
	input  wire        LINE_FREQ_IN,
	input  wire [3:0]  S_AXI_AWADDR_IN,
	input  wire        S_AXI_AWVALID_IN,
	output reg         S_AXI_AWREADY_OUT,
	input  wire [31:0] S_AXI_WDATA_IN,
	input  wire [3:0]  S_AXI_WSTRB_IN,
	input  wire        S_AXI_WVALID_IN,
	output reg         S_AXI_WREADY_OUT,
	output reg  [1:0]  S_AXI_BRESP_OUT,
	output reg         S_AXI_BVALID_OUT,
	input  wire        S_AXI_BREADY_IN,
	input  wire [3:0]  S_AXI_ARADDR_IN,
	input  wire        S_AXI_ARVALID_IN,
	output reg         S_AXI_ARREADY_OUT,
	output reg  [31:0] S_AXI_RDATA_OUT,
	output reg  [1:0]  S_AXI_RRESP_OUT,
	output reg         S_AXI_RVALID_OUT,
	input  wire        S_AXI_RREADY_IN,
	output reg         OVERFLOW_IRQ_OUT,
	output reg         IRQ_OUT
);
	// ****************************************
	// Registers
	// ****************************************
	reg        go_reg;
	reg [1:0]  mode_reg;
	reg [2:0]  rate_reg;
	reg        ovie_reg;
	reg        ovfl_reg;
	reg [15:0] count_reg;
	reg        sts_reg;
	reg        mask_reg;
	reg [3:0]  aw_addr_reg;
	reg        aw_have_reg;
	reg [31:0] w_data_reg;
	reg [3:0]  w_strb_reg;
	reg        w_have_reg;
	reg [2:0]  ev_sync_reg;
	reg [2:0]  ln_sync_reg;
	wire [5:0] tick;
	pic_prescaler u_pre (
		.clk_in   (CLK_IN),
		.rst_in   (RST_IN),
		.ce_in    (CE_IN),
		.tick_out (tick)
	);
	// ****************************************
	// External sources: two-flop sync plus edge
	// ****************************************
	always @(posedge CLK_IN) begin
		if (RST_IN) begin
			ev_sync_reg <= 3'h0;
			ln_sync_reg <= 3'h0;
		end else if (CE_IN) begin
			ev_sync_reg <= {ev_sync_reg[1:0], EVENT_INPUT_ONE_IN};
			ln_sync_reg <= {ln_sync_reg[1:0], LINE_FREQ_IN};
		end
	end
	wire ev_edge = ev_sync_reg[1] && !ev_sync_reg[2];
	wire ln_edge = ln_sync_reg[1] && !ln_sync_reg[2];
	// ****************************************
	// Source select
	// ****************************************
	function src_sel;
		input [2:0] r;
		input [5:0] t;
		input       e;
		input       l;
		begin
			case (r)
				`PIC_RATE_STOP: src_sel = 1'b0;
				`PIC_RATE_1M:   src_sel = t[1];
				`PIC_RATE_100K: src_sel = t[2];
				`PIC_RATE_10K:  src_sel = t[3];
				`PIC_RATE_1K:   src_sel = t[4];
				`PIC_RATE_100:  src_sel = t[5];
				`PIC_RATE_EXT:  src_sel = e;
				default:        src_sel = l;
			endcase
		end
	endfunction
	wire count_tick = go_reg && src_sel(rate_reg, tick, ev_edge, ln_edge);
	wire overflow   = count_tick && (count_reg == 16'hFFFF);
	// ****************************************
	// Bus decode
	// ****************************************
	wire aw_ok  = aw_have_reg || S_AXI_AWVALID_IN;
	wire w_ok   = w_have_reg || S_AXI_WVALID_IN;
	wire [3:0]  wa   = aw_have_reg ? aw_addr_reg : S_AXI_AWADDR_IN;
	wire [31:0] wd   = w_have_reg ? w_data_reg : S_AXI_WDATA_IN;
	wire [3:0]  ws   = w_have_reg ? w_strb_reg : S_AXI_WSTRB_IN;
	wire do_wr  = CE_IN && aw_ok && w_ok && !S_AXI_BVALID_OUT;
	wire wr_ctl = do_wr && (wa == `PIC_OFF_CTRL) && ws[0];
	wire wr_sts = do_wr && (wa == `PIC_OFF_STATUS) && ws[0];
	wire wr_msk = do_wr && (wa == `PIC_OFF_MASK) && ws[0];
	wire go_rise = wr_ctl && wd[`PIC_CTRL_GO] && !go_reg;
	function self_clears;
		input [1:0] m;
		begin
			self_clears = (m == `PIC_MODE_ONESHOT);
		end
	endfunction
	function map_hit;
		input [3:0] a;
		begin
			map_hit = (a == `PIC_OFF_CTRL) || (a == `PIC_OFF_COUNT) ||
				(a == `PIC_OFF_STATUS) || (a == `PIC_OFF_MASK);
		end
	endfunction
	// ****************************************
	// Control next state
	// ****************************************
	reg        go_next;
	reg        ovfl_next;
	reg [15:0] count_next;
	always @* begin
		go_next    = go_reg;
		ovfl_next  = ovfl_reg;
		count_next = count_reg;
		if (wr_ctl) begin
			go_next = wd[`PIC_CTRL_GO];
		end
		if (overflow && self_clears(mode_reg) && !(wr_ctl && wd[`PIC_CTRL_GO])) begin
			go_next = 1'b0;
		end
		if (overflow) begin
			ovfl_next = 1'b1;
		end else if (go_rise || (wr_ctl && !wd[`PIC_CTRL_OVFL])) begin
			ovfl_next = 1'b0;
		end
		if (!go_reg) begin
			count_next = 16'h0000;
		end else if (count_tick) begin
			count_next = count_reg + 16'h0001;
		end
	end
	// ****************************************
	// Control and counter
	// ****************************************
	always @(posedge CLK_IN) begin
		if (RST_IN) begin
			go_reg    <= 1'b0;
			mode_reg  <= 2'h0;
			rate_reg  <= 3'h0;
			ovie_reg  <= 1'b0;
			ovfl_reg  <= 1'b0;
			count_reg <= 16'h0000;
		end else if (CE_IN) begin
			if (wr_ctl) begin
				mode_reg <= wd[`PIC_CTRL_MODE_HI:`PIC_CTRL_MODE_LO];
				rate_reg <= wd[`PIC_CTRL_RATE_HI:`PIC_CTRL_RATE_LO];
				ovie_reg <= wd[`PIC_CTRL_OVIE];
			end
			go_reg    <= go_next;
			ovfl_reg  <= ovfl_next;
			count_reg <= count_next;
		end
	end
	// ****************************************
	// Status next state
	// ****************************************
	reg sts_next;
	always @* begin
		sts_next = sts_reg;
		if (overflow) begin
			sts_next = 1'b1;
		end else if (wr_sts && wd[`PIC_EV_OVF]) begin
			sts_next = 1'b0;
		end
	end
	// ****************************************
	// Interrupt status and mask
	// ****************************************
	always @(posedge CLK_IN) begin
		if (RST_IN) begin
			sts_reg          <= 1'b0;
			mask_reg         <= 1'b0;
			OVERFLOW_IRQ_OUT <= 1'b0;
			IRQ_OUT          <= 1'b0;
		end else if (CE_IN) begin
			sts_reg <= sts_next;
			if (wr_msk) begin
				mask_reg <= wd[`PIC_EV_OVF];
			end
			OVERFLOW_IRQ_OUT <= ovfl_reg && ovie_reg && !(wr_ctl && !wd[`PIC_CTRL_OVIE]);
			IRQ_OUT          <= sts_reg && mask_reg;
		end
	end
	// ****************************************
	// AXI4-Lite write channel
	// ****************************************
	always @(posedge CLK_IN) begin
		if (RST_IN) begin
			aw_have_reg       <= 1'b0;
			w_have_reg        <= 1'b0;
			aw_addr_reg       <= 4'h0;
			w_data_reg        <= 32'h00000000;
			w_strb_reg        <= 4'h0;
			S_AXI_AWREADY_OUT <= 1'b0;
			S_AXI_WREADY_OUT  <= 1'b0;
			S_AXI_BVALID_OUT  <= 1'b0;
			S_AXI_BRESP_OUT   <= `PIC_RESP_OKAY;
		end else if (CE_IN) begin
			S_AXI_AWREADY_OUT <= 1'b0;
			S_AXI_WREADY_OUT  <= 1'b0;
			if (S_AXI_AWVALID_IN && !aw_have_reg && !S_AXI_AWREADY_OUT) begin
				aw_have_reg       <= 1'b1;
				aw_addr_reg       <= S_AXI_AWADDR_IN;
				S_AXI_AWREADY_OUT <= 1'b1;
			end
			if (S_AXI_WVALID_IN && !w_have_reg && !S_AXI_WREADY_OUT) begin
				w_have_reg       <= 1'b1;
				w_data_reg       <= S_AXI_WDATA_IN;
				w_strb_reg       <= S_AXI_WSTRB_IN;
				S_AXI_WREADY_OUT <= 1'b1;
			end
			if (aw_have_reg && w_have_reg && !S_AXI_BVALID_OUT) begin
				aw_have_reg      <= 1'b0;
				w_have_reg       <= 1'b0;
				S_AXI_BVALID_OUT <= 1'b1;
				S_AXI_BRESP_OUT  <= map_hit(aw_addr_reg) ? `PIC_RESP_OKAY : `PIC_RESP_SLVERR;
			end else if (S_AXI_BVALID_OUT && S_AXI_BREADY_IN) begin
				S_AXI_BVALID_OUT <= 1'b0;
			end
		end
	end
	// ****************************************
	// Read word select
	// ****************************************
	reg [31:0] rd_word;
	always @* begin
		rd_word = 32'h00000000;
		case (S_AXI_ARADDR_IN)
			`PIC_OFF_CTRL:   rd_word = {24'h000000, ovfl_reg, ovie_reg, rate_reg, mode_reg, go_reg};
			`PIC_OFF_COUNT:  rd_word = {16'h0000, count_reg};
			`PIC_OFF_STATUS: rd_word = {31'h00000000, sts_reg};
			`PIC_OFF_MASK:   rd_word = {31'h00000000, mask_reg};
			default:         rd_word = 32'h00000000;
		endcase
	end
	// ****************************************
	// AXI4-Lite read channel
	// ****************************************
	always @(posedge CLK_IN) begin
		if (RST_IN) begin
			S_AXI_ARREADY_OUT <= 1'b0;
			S_AXI_RVALID_OUT  <= 1'b0;
			S_AXI_RDATA_OUT   <= 32'h00000000;
			S_AXI_RRESP_OUT   <= `PIC_RESP_OKAY;
		end else if (CE_IN) begin
			S_AXI_ARREADY_OUT <= 1'b0;
			if (S_AXI_ARVALID_IN && !S_AXI_ARREADY_OUT && !S_AXI_RVALID_OUT) begin
				S_AXI_ARREADY_OUT <= 1'b1;
				S_AXI_RVALID_OUT  <= 1'b1;
				S_AXI_RRESP_OUT   <= map_hit(S_AXI_ARADDR_IN) ? `PIC_RESP_OKAY : `PIC_RESP_SLVERR;
				S_AXI_RDATA_OUT   <= rd_word;
			end else if (S_AXI_RVALID_OUT && S_AXI_RREADY_IN) begin
				S_AXI_RVALID_OUT <= 1'b0;
			end
		end
	end
endmodule // pic_clock_ctrl
`default_nettype wire

//--- pic_consts.vh
`ifndef PIC_CONSTS_VH
`define PIC_CONSTS_VH
`define PIC_ADDR_W        4
`define PIC_OFF_CTRL      4'h0
`define PIC_OFF_COUNT     4'h4
`define PIC_OFF_STATUS    4'h8
`define PIC_OFF_MASK      4'hC
`define PIC_CTRL_GO       0
`define PIC_CTRL_MODE_LO  1
`define PIC_CTRL_MODE_HI  2
`define PIC_CTRL_RATE_LO  3
`define PIC_CTRL_RATE_HI  5
`define PIC_CTRL_OVIE     6
`define PIC_CTRL_OVFL     7
`define PIC_CTRL_RESET    16'h0000
`define PIC_MODE_ONESHOT  2'h0
`define PIC_RATE_STOP     3'h0
`define PIC_RATE_1M       3'h1
`define PIC_RATE_100K     3'h2
`define PIC_RATE_10K      3'h3
`define PIC_RATE_1K       3'h4
`define PIC_RATE_100      3'h5
`define PIC_RATE_EXT      3'h6
`define PIC_RATE_LINE     3'h7
`define PIC_CLK_HZ        40000000
`define PIC_OSC_HZ        10000000
`define PIC_OSC_DIV       (`PIC_CLK_HZ / `PIC_OSC_HZ)
`define PIC_DEC_DIV       10
`define PIC_OSC_LAST      2'h3
`define PIC_DEC_LAST      4'h9
`define PIC_EV_OVF        0
`define PIC_RESP_OKAY     2'h0
`define PIC_RESP_SLVERR   2'h2
`endif

//--- pic_prescaler.v
`timescale 1ns/1ps
`default_nettype none
`include "pic_consts.vh"
module pic_prescaler (
	input  wire       clk_in,
	input  wire       rst_in,
	input  wire       ce_in,
	output reg  [5:0] tick_out
);
	// ****************************************
	// 10 MHz oscillator and decade dividers
	// ****************************************
	reg [1:0] osc_reg;
	reg [3:0] dec_reg [0:4];
	wire [5:0] carry;
	assign carry[0] = (osc_reg == `PIC_OSC_LAST);
	genvar g;
	generate
		for (g = 0; g < 5; g = g + 1) begin : g_dec
			assign carry[g+1] = carry[g] && (dec_reg[g] == `PIC_DEC_LAST);
			always @(posedge clk_in) begin
				if (rst_in) begin
					dec_reg[g] <= 4'h0;
				end else if (ce_in && carry[g]) begin
					dec_reg[g] <= carry[g+1] ? 4'h0 : dec_reg[g] + 4'h1;
				end
			end
		end
	endgenerate
	always @(posedge clk_in) begin
		if (rst_in) begin
			osc_reg  <= 2'h0;
			tick_out <= 6'h00;
		end else if (ce_in) begin
			osc_reg  <= carry[0] ? 2'h0 : osc_reg + 2'h1;
			tick_out <= carry; // bit0 10MHz .. bit5 100Hz
		end
	end
endmodule // pic_prescaler
`default_nettype wire

//--- pic_clock_ctrl_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// Checker
// ****
module pic_clock_ctrl_asserts (
	input wire logic        CLK_IN,
	input wire logic        RST_IN,
	input wire logic [3:0]  S_AXI_AWADDR_IN,
	input wire logic        S_AXI_AWVALID_IN,
	input wire logic        S_AXI_AWREADY_OUT,
	input wire logic [31:0] S_AXI_WDATA_IN,
	input wire logic [3:0]  S_AXI_WSTRB_IN,
	input wire logic        S_AXI_WVALID_IN,
	input wire logic        S_AXI_WREADY_OUT,
	input wire logic        S_AXI_BVALID_OUT,
	input wire logic        S_AXI_BREADY_IN,
	input wire logic [3:0]  S_AXI_ARADDR_IN,
	input wire logic        S_AXI_ARVALID_IN,
	input wire logic        S_AXI_ARREADY_OUT,
	input wire logic [31:0] S_AXI_RDATA_OUT,
	input wire logic        S_AXI_RVALID_OUT,
	input wire logic        S_AXI_RREADY_IN,
	input wire logic        OVERFLOW_IRQ_OUT
);
	logic [3:0]  wa_reg;
	logic [31:0] wd_reg;
	logic [3:0]  ws_reg;
	logic        bq_reg;
	logic [1:0]  mw_reg;
	logic [2:0]  rw_reg;
	logic        gw_reg;
	// Shadow of the last control write
	always @(posedge CLK_IN) begin
		bq_reg <= S_AXI_BVALID_OUT;
		if (RST_IN) begin
			{wa_reg, wd_reg, ws_reg, mw_reg, rw_reg, gw_reg} <= '0;
		end else begin
			if (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT) wa_reg <= S_AXI_AWADDR_IN;
			if (S_AXI_WVALID_IN && S_AXI_WREADY_OUT) {wd_reg, ws_reg} <= {S_AXI_WDATA_IN, S_AXI_WSTRB_IN};
			if (S_AXI_BVALID_OUT && !bq_reg && wa_reg == 4'h0 && ws_reg[0]) begin
				{rw_reg, mw_reg, gw_reg} <= wd_reg[5:0];
			end
		end
	end
	default clocking @(posedge CLK_IN); endclocking
	default disable iff (RST_IN);
	sequence s_wr_ctrl;
		$rose(S_AXI_BVALID_OUT) && wa_reg == 4'h0 && ws_reg[0];
	endsequence
	sequence s_rd(logic [3:0] a);
		$rose(S_AXI_RVALID_OUT) && S_AXI_ARADDR_IN == a;
	endsequence
	AST_IRQ_CANCEL: assert property (s_wr_ctrl ##0 !wd_reg[6] |-> !OVERFLOW_IRQ_OUT)
		else $error("overflow request kept after enable cleared");
	AST_IRQ_RAISE: assert property (s_rd(4'h0) ##0 S_AXI_RDATA_OUT[7:6] == 2'h3 |-> ##[0:1] OVERFLOW_IRQ_OUT)
		else $error("enabled overflow flag without request");
	AST_MODE_RB: assert property (s_rd(4'h0) |-> S_AXI_RDATA_OUT[2:1] == mw_reg)
		else $error("mode field readback wrong");
	AST_RATE_RB: assert property (s_rd(4'h0) |-> S_AXI_RDATA_OUT[5:3] == rw_reg)
		else $error("rate field readback wrong");
	AST_RUN_HOLD: assert property (s_rd(4'h0) ##0 (gw_reg && mw_reg != 2'h0) |-> S_AXI_RDATA_OUT[0])
		else $error("run bit lost in repeating mode");
	AST_ZERO_HOLD: assert property (s_rd(4'h4) ##0 !gw_reg |-> S_AXI_RDATA_OUT == 32'h0)
		else $error("counter not zero while stopped");
	AST_RD_ANSWER: assert property (S_AXI_ARVALID_IN && !S_AXI_ARREADY_OUT && !S_AXI_RVALID_OUT
		|=> S_AXI_ARREADY_OUT && S_AXI_RVALID_OUT) else $error("read answer late");
	AST_B_ONCE: assert property (S_AXI_BVALID_OUT && S_AXI_BREADY_IN |=> !S_AXI_BVALID_OUT)
		else $error("write response repeated");
	AST_R_ONCE: assert property (S_AXI_RVALID_OUT && S_AXI_RREADY_IN |=> !S_AXI_RVALID_OUT)
		else $error("read response repeated");
endmodule // pic_clock_ctrl_asserts
bind pic_clock_ctrl pic_clock_ctrl_asserts i_chk (.*);
`default_nettype wire

//--- pic_event_src.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// Event source model
// ****
module pic_event_src (
	input  wire logic       clk_in,
	input  wire logic       rst_in,
	input  wire logic       start_in,
	input  wire logic [4:0] count_in,
	output var  logic       ev_out,
	output wire logic       busy_out
);
	logic [4:0] left_reg;
	logic [2:0] ph_reg;
	assign busy_out = (left_reg != 5'h0);
	// Pulses high 3 cycles, low 3 cycles
	always @(posedge clk_in) begin
		if (rst_in || start_in) begin
			left_reg <= rst_in ? 5'h0 : count_in;
			ph_reg <= 3'h0;
			ev_out <= 1'b0;
		end else if (busy_out) begin
			ph_reg <= ph_reg + 3'h1;
			if (ph_reg == 3'h2) ev_out <= 1'b1;
			if (ph_reg == 3'h5) begin
				ev_out <= 1'b0;
				ph_reg <= 3'h0;
				left_reg <= left_reg - 5'h1;
			end
		end
	end
endmodule // pic_event_src
`default_nettype wire

//--- programmable_interval_clock_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// Testbench
// ****
module programmable_interval_clock_control_tb;
	logic        clk = 0, rst = 1, aw_v = 0, w_v = 0, ar_v = 0, awr, wrd, bv, arr, rv, irq, oirq;
	logic        st = 0, sel = 0, ev, busy, ce = 1;
	logic [31:0] d2;
	logic [3:0]  aw_a = 4'h0, ar_a = 4'h0;
	logic [31:0] w_d = 32'h0, rdat, d;
	logic [1:0]  br, rr;
	logic [4:0]  k = 5'h0;
	integer      seed = 32'h58F95272, bad_count = 0, total_checks = 0;
	always #12.5 clk = ~clk;
	pic_clock_ctrl i_dut (.CLK_IN(clk), .RST_IN(rst), .CE_IN(ce),
		.EVENT_INPUT_ONE_IN(ev & !sel), .LINE_FREQ_IN(ev & sel),
		.S_AXI_AWADDR_IN(aw_a), .S_AXI_AWVALID_IN(aw_v), .S_AXI_AWREADY_OUT(awr),
		.S_AXI_WDATA_IN(w_d), .S_AXI_WSTRB_IN(4'hF), .S_AXI_WVALID_IN(w_v), .S_AXI_WREADY_OUT(wrd),
		.S_AXI_BRESP_OUT(br), .S_AXI_BVALID_OUT(bv), .S_AXI_BREADY_IN(1'b1),
		.S_AXI_ARADDR_IN(ar_a), .S_AXI_ARVALID_IN(ar_v), .S_AXI_ARREADY_OUT(arr),
		.S_AXI_RDATA_OUT(rdat), .S_AXI_RRESP_OUT(rr), .S_AXI_RVALID_OUT(rv), .S_AXI_RREADY_IN(1'b1),
		.OVERFLOW_IRQ_OUT(oirq), .IRQ_OUT(irq));
	pic_event_src i_src (.clk_in(clk), .rst_in(rst), .start_in(st), .count_in(k), .ev_out(ev), .busy_out(busy));
	function automatic logic [31:0] ctrl(input logic [2:0] r, input logic [1:0] m, input logic g);
		return {26'h0, r, m, g};
	endfunction
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		total_checks++;
		if (s !== e) begin
			bad_count++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] dt);
		logic pa, pw;
		pa = 1;
		pw = 1;
		aw_a <= a; w_d <= dt; aw_v <= 1; w_v <= 1;
		repeat (50) begin
			@(posedge clk);
			if (bv === 1'b1) break;
			if (awr) pa = 0;
			if (wrd) pw = 0;
			aw_v <= pa; w_v <= pw;
		end
	endtask
	task automatic rd(input logic [3:0] a, output logic [31:0] dt);
		ar_a <= a; ar_v <= 1;
		repeat (50) begin
			@(posedge clk);
			if (rv === 1'b1) break;
		end
		dt = rdat;
		ar_v <= 0;
		@(posedge clk);
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (6) @(posedge clk);
		rst <= 0;
		@(posedge clk);
		rd(4'h0, d); chk(d, 32'h0);
		rd(4'h4, d); chk(d, 32'h0);
		for (int i = 0; i < 8; i++) begin
			wr(4'h0, ctrl(i, i, 0)); rd(4'h0, d); chk(d, ctrl(i, i, 0));
		end
		wr(4'hC, 32'h1); rd(4'hC, d); chk(d, 32'h1);
		wr(4'h8, 32'h1); rd(4'h8, d); chk(d, 32'h0);
		chk(irq, 1'b0);
		chk(oirq, 1'b0);
		rd(4'h2, d); chk(d, 32'h0);
		chk(rr, 2'h2);
		wr(4'h2, 32'hFF); chk(br, 2'h2);
		wr(4'h0, 32'h0); chk(br, 2'h0);
		$display("register test done");
		wr(4'h0, ctrl(0, 1, 1)); repeat (200) @(posedge clk);
		rd(4'h4, d); chk(d, 32'h0);
		rd(4'h0, d); chk(d[0], 1);
		for (int r = 1; r < 4; r++) begin
			wr(4'h0, ctrl(r, 1, 1)); repeat (100 * 10 ** (r - 1)) @(posedge clk);
			rd(4'h4, d); chk(d >= 2 && d <= 3, 1);
			wr(4'h0, ctrl(r, 1, 0)); rd(4'h4, d); chk(d, 32'h0);
		end
		wr(4'h0, ctrl(1, 1, 1)); repeat (100) @(posedge clk);
		rd(4'h4, d);
		ce <= 0; repeat (400) @(posedge clk); ce <= 1;
		rd(4'h4, d2); chk(d2 - d <= 1, 1);
		wr(4'h0, ctrl(1, 1, 0)); rd(4'h4, d); chk(d, 32'h0);
		$display("rate test done");
		for (int s = 0; s < 2; s++) begin
			sel <= s; k <= 5'h1 + 5'($random(seed) & 15);
			wr(4'h0, ctrl(6 + s, 2 * s, 1));
			st <= 1; @(posedge clk); st <= 0;
			repeat (400) begin @(posedge clk); if (!busy) break; end
			repeat (5) @(posedge clk);
			rd(4'h4, d); chk(d, {27'h0, k});
			wr(4'h0, ctrl(6 + s, 2 * s, 0)); rd(4'h4, d); chk(d, 32'h0);
		end
		$display("event test done");
		conclude();
	end
	initial begin
		repeat (60000) @(posedge clk);
		bad_count++;
		conclude();
	end
endmodule // programmable_interval_clock_control_tb
`default_nettype wire
